/* pkg/io_bridge_pkg.sv */
// Package for the I/O bridge control block: indexed offsets, field positions, resets.
// Assumes the registers sit behind a 7-bit index / 32-bit data pair on the host clock.
package io_bridge_pkg;

    // ------------------------------------------------------------
    // Index pair layout
    // ------------------------------------------------------------
    localparam int unsigned INDEX_ADDR_W   = 7;
    localparam int unsigned INDEX_WREN_BIT = 7;

    // ------------------------------------------------------------
    // Indexed register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] LINK_CFG_IDX  = 7'h08;
    localparam logic [6:0] DMA_ARB_IDX   = 7'h09;
    localparam logic [6:0] CSR_CNT_IDX   = 7'h0a;
    localparam logic [6:0] PCIE_CNTL_IDX = 7'h0b;
    localparam logic [6:0] P2P_CNTL_IDX  = 7'h0c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] LINK_CFG_RST  = 32'h07e0_0030;
    localparam logic [31:0] DMA_ARB_RST   = 32'h0000_0000;
    localparam logic [31:0] CSR_CNT_RST   = 32'h0000_0000;
    localparam logic [31:0] PCIE_CNTL_RST = 32'h0040_0100;
    localparam logic [31:0] P2P_CNTL_RST  = 32'h0000_1700;

    // Writable masks (bit 16 of control is a hardware status bit)
    localparam logic [31:0] PCIE_CNTL_WMASK = 32'h1dfe_3f9f;
    localparam logic [31:0] P2P_CNTL_WMASK  = 32'h0000_7ffc;

    // ------------------------------------------------------------
    // Link configuration fields
    // ------------------------------------------------------------
    localparam int unsigned GP_HOLD_LO    = 20;
    localparam int unsigned GP_HOLD_N     = 7;
    localparam int unsigned GP_CAL_RST    = 30;
    localparam int unsigned GP_CORE_RST   = 31;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned DMA_RO_VAL     = 0;
    localparam int unsigned DMA_SNOOP_VAL  = 1;
    localparam int unsigned DMA_ATTR_EN    = 2;
    localparam int unsigned P2SB_DIS       = 3;
    localparam int unsigned BM_IGNORE      = 7;
    localparam int unsigned MST_ORDER_EN   = 8;
    localparam int unsigned NS_BLOCK       = 9;
    localparam int unsigned SN_BLOCK       = 10;
    localparam int unsigned MST_RO_VAL     = 11;
    localparam int unsigned MST_RO_EN      = 12;
    localparam int unsigned MST_NS_EN      = 13;
    localparam int unsigned EXT_PRESENT    = 16;
    localparam int unsigned EXT_RETRY_EN   = 17;
    localparam int unsigned RETRY_EN       = 18;
    localparam int unsigned INT_GROUP      = 19;
    localparam int unsigned SLOT_PWR_EN    = 20;
    localparam int unsigned SLOT_LIM_EN    = 21;
    localparam int unsigned INV_DMA_EN     = 22;
    localparam int unsigned PME_EN         = 23;
    localparam int unsigned LOCK_BYP_OFF   = 24;
    localparam int unsigned INV_DMA_MODE   = 26;
    localparam int unsigned RETRY_ID_CTL   = 28;

    // ------------------------------------------------------------
    // Peer bridge control fields
    // ------------------------------------------------------------
    localparam int unsigned HIDE_LO        = 2;
    localparam int unsigned HIDE_N         = 6;
    localparam int unsigned GFX_SYNC_EN    = 8;
    localparam int unsigned SB_SYNC_EN     = 9;
    localparam int unsigned MSG_SYNC_EN    = 10;
    localparam int unsigned LINKDOWN_RST   = 11;
    localparam int unsigned NONDEV0_FWD    = 12;

    localparam logic [15:0] RETRY_ID_VALUE = 16'h0001;

endpackage

/* rtl/io_bridge_pcie_control.sv */
// Control registers of the I/O bridge and the request steering they apply.
// Assumes all inputs are synchronous to sys_clk_i; index/data reached over plain ports.
//
// Overview of operation
// RQ1 - Port hold bits block link training while set; ports one to six default held.
// RQ2 - Calibration reset bit holds GP link calibration logic in reset.
// RQ3 - Global reset bit holds GP link core logic in reset.
// RQ4 - Attribute override replaces DMA relaxed-order and snoop with stored values.
// RQ5 - Peer disable blocks peer transactions targeting the southbridge.
// RQ6 - Bus master ignore drops southbridge bus-master trigger events.
// RQ7 - Master read ordering enforced while ordering bit set, default set.
// RQ8 - With arbitration off, block nonsnoop or snoop DMA per block bits.
// RQ9 - Master relaxed-order override applies stored value to master requests.
// RQ10 - Master nonsnoop enable marks master requests nonsnoop.
// RQ11 - Retry handling only when enabled; external devices only when also enabled.
// RQ12 - Status bit reports an external device is plugged in.
// RQ13 - Interrupt group select maps legacy lines to A-D or E-H.
// RQ14 - Slot power and slot limit messages forwarded only when enabled.
// RQ15 - Invalid DMA handling: mode 0 unsupported completion, mode 1 drop.
// RQ16 - PME turn-off and acknowledge exchanged only while enabled.
// RQ17 - Lock ordering bypass disabled for locked transactions when bit set.
// RQ18 - Retry responses return ID 0x0001 when control is zero.
// RQ19 - Bridge of device N hidden when hide bit N set, N two to seven.
// RQ20 - Graphics, southbridge, message paths double-flopped when enabled, default on.
// RQ21 - Link-down with reset enable clears shadowed PCIe registers.
// RQ22 - Type-0 config not to device 0 forwarded to southbridge when enabled.
// RQ23 - Index register holds 7-bit index and write enable; data writes gated.
// RQ24 - Control bits reset to defaults and read back last written value.
`timescale 1ns/100ps

module io_bridge_pcie_control
    import io_bridge_pkg::*;
#(
    parameter int unsigned GFX_W = 8,
    parameter int unsigned SB_W  = 8,
    parameter int unsigned MSG_W = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // Index / data access
    input  wire logic        index_wr_i,
    input  wire logic [31:0] index_wdata_i,
    output logic      [31:0] index_rdata_o,
    input  wire logic        data_wr_i,
    input  wire logic [31:0] data_wdata_i,
    output logic      [31:0] data_rdata_o,
    // Link side
    output logic      [6:0]  gp_training_hold_o,
    output logic             gp_calibration_reset_o,
    output logic             gp_core_reset_o,
    input  wire logic        link_down_i,
    output logic             shadow_reset_o,
    // DMA attributes
    input  wire logic        dma_req_i,
    input  wire logic        dma_ro_i,
    input  wire logic        dma_snoop_i,
    input  wire logic        dma_invalid_i,
    input  wire logic        dma_posted_i,
    input  wire logic        pm_arbitration_off_i,
    output logic             dma_ro_o,
    output logic             dma_snoop_o,
    output logic             dma_block_o,
    output logic             dma_drop_o,
    output logic             dma_unsupported_o,
    // Master attributes
    input  wire logic        mst_ro_i,
    output logic             mst_ro_o,
    output logic             mst_nonsnoop_o,
    output logic             mst_read_order_o,
    output logic             lock_bypass_allow_o,
    // Peer and bus-master events
    input  wire logic        p2p_to_sb_i,
    output logic             p2p_allow_o,
    input  wire logic        bm_event_i,
    output logic             bm_event_o,
    // Retry handling
    input  wire logic        external_device_present_i,
    output logic             retry_handling_o,
    output logic             ext_retry_handling_o,
    output logic             retry_id_valid_o,
    output logic      [15:0] retry_id_o,
    // Interrupts and messages
    input  wire logic [3:0]  legacy_int_i,
    output logic      [7:0]  legacy_int_o,
    input  wire logic        slot_power_msg_i,
    output logic             slot_power_msg_o,
    input  wire logic        slot_limit_msg_i,
    output logic             slot_limit_msg_o,
    input  wire logic        pme_msg_i,
    output logic             pme_msg_o,
    // Configuration decode
    input  wire logic        cfg_req_i,
    input  wire logic        cfg_type0_ext_i,
    input  wire logic [4:0]  cfg_device_i,
    output logic             cfg_to_sb_o,
    output logic             cfg_hidden_o,
    // Synchronised paths
    input  wire logic [GFX_W-1:0] gfx_path_i,
    output logic      [GFX_W-1:0] gfx_path_o,
    input  wire logic [SB_W-1:0]  sb_path_i,
    output logic      [SB_W-1:0]  sb_path_o,
    input  wire logic [MSG_W-1:0] msg_path_i,
    output logic      [MSG_W-1:0] msg_path_o
);

    // Elaboration check: path widths must be non-zero
    if (GFX_W == 0 || SB_W == 0 || MSG_W == 0) begin : g_bad_width
        $error("path widths must be at least one");
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [6:0]  index_ptr;
    logic        index_wren;
    logic [31:0] link_cfg;
    logic [31:0] dma_arb;
    logic [31:0] csr_cnt;
    logic [31:0] pcie_cntl;
    logic [31:0] p2p_cntl;
    logic        data_we;
    logic        shadow_clear;

    assign data_we      = data_wr_i && index_wren;                           // [RQ23]
    assign shadow_clear = link_down_i && p2p_cntl[LINKDOWN_RST];            // [RQ21]

    // Index register: pointer plus write enable
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            index_ptr  <= 7'h00;
            index_wren <= 1'b0;
        end else if (index_wr_i) begin
            index_ptr  <= index_wdata_i[INDEX_ADDR_W-1:0];                  // [RQ23]
            index_wren <= index_wdata_i[INDEX_WREN_BIT];
        end
    end

    // Link configuration; treated as shadowed PCIe state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || shadow_clear) begin
            link_cfg <= LINK_CFG_RST;                                        // [RQ24] [RQ21]
        end else if (data_we && index_ptr == LINK_CFG_IDX) begin
            link_cfg <= data_wdata_i;
        end
    end

    // Arbiter and retry counters, plain storage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dma_arb <= DMA_ARB_RST;
            csr_cnt <= CSR_CNT_RST;
        end else begin
            if (data_we && index_ptr == DMA_ARB_IDX) begin
                dma_arb <= data_wdata_i;
            end
            if (data_we && index_ptr == CSR_CNT_IDX) begin
                csr_cnt <= data_wdata_i;
            end
        end
    end

    // Control register; presence bit follows hardware, not software
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pcie_cntl <= PCIE_CNTL_RST;
        end else begin
            if (data_we && index_ptr == PCIE_CNTL_IDX) begin
                pcie_cntl <= data_wdata_i & PCIE_CNTL_WMASK;
            end else begin
                pcie_cntl <= pcie_cntl & PCIE_CNTL_WMASK;
            end
            pcie_cntl[EXT_PRESENT] <= external_device_present_i;            // [RQ12]
        end
    end

    // Peer bridge control
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            p2p_cntl <= P2P_CNTL_RST;
        end else if (data_we && index_ptr == P2P_CNTL_IDX) begin
            p2p_cntl <= data_wdata_i & P2P_CNTL_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Read path, registered data outputs
    // ------------------------------------------------------------
    logic [31:0] next_data;

    // Unknown indices read zero
    always_comb begin
        case (index_ptr)
            LINK_CFG_IDX:  next_data = link_cfg;                             // [RQ24]
            DMA_ARB_IDX:   next_data = dma_arb;
            CSR_CNT_IDX:   next_data = csr_cnt;
            PCIE_CNTL_IDX: next_data = pcie_cntl;
            P2P_CNTL_IDX:  next_data = p2p_cntl;
            default:       next_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            data_rdata_o  <= 32'h0000_0000;
            index_rdata_o <= 32'h0000_0000;
        end else begin
            data_rdata_o  <= next_data;
            index_rdata_o <= {24'h00_0000, index_wren, index_ptr};
        end
    end

    // ------------------------------------------------------------
    // Link reset and training control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gp_training_hold_o     <= LINK_CFG_RST[GP_HOLD_LO +: GP_HOLD_N];
            gp_calibration_reset_o <= LINK_CFG_RST[GP_CAL_RST];
            gp_core_reset_o        <= LINK_CFG_RST[GP_CORE_RST];
            shadow_reset_o         <= 1'b0;
        end else begin
            gp_training_hold_o     <= link_cfg[GP_HOLD_LO +: GP_HOLD_N];     // [RQ1]
            gp_calibration_reset_o <= link_cfg[GP_CAL_RST];                 // [RQ2]
            gp_core_reset_o        <= link_cfg[GP_CORE_RST];                // [RQ3]
            shadow_reset_o         <= shadow_clear;                          // [RQ21]
        end
    end

    // ------------------------------------------------------------
    // DMA and master request steering
    // ------------------------------------------------------------
    // Registered so attribute changes never glitch a request mid-cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dma_ro_o          <= 1'b0;
            dma_snoop_o       <= 1'b0;
            dma_block_o       <= 1'b0;
            dma_drop_o        <= 1'b0;
            dma_unsupported_o <= 1'b0;
        end else begin
            dma_ro_o    <= pcie_cntl[DMA_ATTR_EN] ? pcie_cntl[DMA_RO_VAL]
                                                  : dma_ro_i;                // [RQ4]
            dma_snoop_o <= pcie_cntl[DMA_ATTR_EN] ? pcie_cntl[DMA_SNOOP_VAL]
                                                  : dma_snoop_i;             // [RQ4]
            dma_block_o <= dma_req_i && pm_arbitration_off_i &&
                           ((!dma_snoop_i && pcie_cntl[NS_BLOCK]) ||
                            (dma_snoop_i && pcie_cntl[SN_BLOCK]));           // [RQ8]
            dma_drop_o  <= dma_req_i && dma_invalid_i && pcie_cntl[INV_DMA_EN] &&
                           pcie_cntl[INV_DMA_MODE];                          // [RQ15]
            dma_unsupported_o <= dma_req_i && dma_invalid_i &&
                                 pcie_cntl[INV_DMA_EN] &&
                                 !pcie_cntl[INV_DMA_MODE] && !dma_posted_i;  // [RQ15]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mst_ro_o            <= 1'b0;
            mst_nonsnoop_o      <= 1'b0;
            mst_read_order_o    <= PCIE_CNTL_RST[MST_ORDER_EN];
            lock_bypass_allow_o <= 1'b1;
        end else begin
            mst_ro_o            <= pcie_cntl[MST_RO_EN] ? pcie_cntl[MST_RO_VAL]
                                                        : mst_ro_i;          // [RQ9]
            mst_nonsnoop_o      <= pcie_cntl[MST_NS_EN];                     // [RQ10]
            mst_read_order_o    <= pcie_cntl[MST_ORDER_EN];                  // [RQ7]
            lock_bypass_allow_o <= !pcie_cntl[LOCK_BYP_OFF];                 // [RQ17]
        end
    end

    // ------------------------------------------------------------
    // Events, messages, retry and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            p2p_allow_o      <= 1'b0;
            bm_event_o       <= 1'b0;
            slot_power_msg_o <= 1'b0;
            slot_limit_msg_o <= 1'b0;
            pme_msg_o        <= 1'b0;
            legacy_int_o     <= 8'h00;
        end else begin
            p2p_allow_o      <= p2p_to_sb_i && !pcie_cntl[P2SB_DIS];         // [RQ5]
            bm_event_o       <= bm_event_i && !pcie_cntl[BM_IGNORE];         // [RQ6]
            slot_power_msg_o <= slot_power_msg_i && pcie_cntl[SLOT_PWR_EN];  // [RQ14]
            slot_limit_msg_o <= slot_limit_msg_i && pcie_cntl[SLOT_LIM_EN];  // [RQ14]
            pme_msg_o        <= pme_msg_i && pcie_cntl[PME_EN];              // [RQ16]
            legacy_int_o     <= pcie_cntl[INT_GROUP] ? {legacy_int_i, 4'h0}
                                                     : {4'h0, legacy_int_i}; // [RQ13]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            retry_handling_o     <= 1'b0;
            ext_retry_handling_o <= 1'b0;
            retry_id_valid_o     <= 1'b1;
            retry_id_o           <= RETRY_ID_VALUE;
        end else begin
            retry_handling_o     <= pcie_cntl[RETRY_EN];                     // [RQ11]
            ext_retry_handling_o <= pcie_cntl[RETRY_EN] &&
                                    pcie_cntl[EXT_RETRY_EN];                 // [RQ11]
            retry_id_valid_o     <= !pcie_cntl[RETRY_ID_CTL];                // [RQ18]
            retry_id_o           <= pcie_cntl[RETRY_ID_CTL] ? 16'h0000
                                                            : RETRY_ID_VALUE;
        end
    end

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    logic hide_hit;

    // Hide bit index equals device number, devices two to seven only
    assign hide_hit = (cfg_device_i >= 5'h02) && (cfg_device_i <= 5'h07) &&
                      p2p_cntl[cfg_device_i[2:0]];                          // [RQ19]

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_to_sb_o  <= 1'b0;
            cfg_hidden_o <= 1'b0;
        end else begin
            cfg_hidden_o <= cfg_req_i && hide_hit;                          // [RQ19]
            cfg_to_sb_o  <= cfg_req_i && cfg_type0_ext_i &&
                            cfg_device_i != 5'h00 && p2p_cntl[NONDEV0_FWD]; // [RQ22]
        end
    end

    // ------------------------------------------------------------
    // Optional double-flop paths
    // ------------------------------------------------------------
    // Bypass trades metastability margin for two cycles less latency
    logic [GFX_W-1:0] gfx_s1, gfx_s2;
    logic [SB_W-1:0]  sb_s1, sb_s2;
    logic [MSG_W-1:0] msg_s1, msg_s2;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gfx_s1 <= '0;
            gfx_s2 <= '0;
            sb_s1  <= '0;
            sb_s2  <= '0;
            msg_s1 <= '0;
            msg_s2 <= '0;
        end else begin
            gfx_s1 <= gfx_path_i;
            gfx_s2 <= gfx_s1;
            sb_s1  <= sb_path_i;
            sb_s2  <= sb_s1;
            msg_s1 <= msg_path_i;
            msg_s2 <= msg_s1;
        end
    end

    assign gfx_path_o = p2p_cntl[GFX_SYNC_EN] ? gfx_s2 : gfx_path_i;       // [RQ20]
    assign sb_path_o  = p2p_cntl[SB_SYNC_EN]  ? sb_s2  : sb_path_i;        // [RQ20]
    assign msg_path_o = p2p_cntl[MSG_SYNC_EN] ? msg_s2 : msg_path_i;       // [RQ20]

endmodule

/* sim/io_bridge_pcie_control_sva.sv */
// Checker bound to the I/O bridge control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module io_bridge_pcie_control_sva (
    input logic        sys_clk_i,
    input logic        sys_rst_i,
    input logic        bm_event_i,
    input logic        bm_event_o,
    input logic        p2p_to_sb_i,
    input logic        p2p_allow_o,
    input logic        dma_req_i,
    input logic        dma_invalid_i,
    input logic        dma_posted_i,
    input logic        dma_drop_o,
    input logic        dma_unsupported_o,
    input logic        cfg_req_i,
    input logic        cfg_type0_ext_i,
    input logic [4:0]  cfg_device_i,
    input logic        cfg_to_sb_o,
    input logic        cfg_hidden_o,
    input logic        retry_id_valid_o,
    input logic [15:0] retry_id_o,
    input logic [3:0]  legacy_int_i,
    input logic [7:0]  legacy_int_o,
    input logic        link_down_i,
    input logic        shadow_reset_o
);
    // Gated outputs need their cause one cycle earlier
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    bm_gate_a: assert property (bm_event_o |-> $past(bm_event_i))
        else $error("stray bus master event");
    peer_gate_a: assert property (p2p_allow_o |-> $past(p2p_to_sb_i))
        else $error("stray peer transfer");
    invalid_dma_a: assert property ((dma_drop_o || dma_unsupported_o) |->
        $past(dma_req_i && dma_invalid_i) && !(dma_drop_o && dma_unsupported_o)
        && !(dma_unsupported_o && $past(dma_posted_i)))
        else $error("bad invalid dma handling");
    cfg_forward_a: assert property (cfg_to_sb_o |->
        $past(cfg_req_i && cfg_type0_ext_i && cfg_device_i != 5'h00))
        else $error("stray config forward");
    bridge_hide_a: assert property (cfg_hidden_o |->
        $past(cfg_device_i) >= 5'h02 && $past(cfg_device_i) <= 5'h07)
        else $error("hide outside devices 2 to 7");
    retry_id_a: assert property (retry_id_o == (retry_id_valid_o ? 16'h0001 : 16'h0000))
        else $error("bad retry id");
    int_group_a: assert property (legacy_int_o == {4'h0, $past(legacy_int_i)} ||
        legacy_int_o == {$past(legacy_int_i), 4'h0})
        else $error("bad interrupt mapping");
    link_down_a: assert property (shadow_reset_o |-> $past(link_down_i))
        else $error("stray shadow reset");
endmodule

bind io_bridge_pcie_control io_bridge_pcie_control_sva u_sva (.*);

/* sim/io_far_side_model.sv */
// Far-side model: DMA and configuration requests to the bridge.
// Assumes bench fields change at falling edges; drives them 1 ns later.
`timescale 1ns/100ps

module io_far_side_model (
    input  logic        sys_clk_i,
    input  logic        cmd_valid_i,
    input  logic [11:0] cmd_i,
    output logic [11:0] req_o
);
    // Idle: strobes low, qualifiers inverted so stale fields never look held
    initial req_o = 12'h000;
    always @(negedge sys_clk_i) #1 begin
        if (cmd_valid_i) begin
            req_o <= cmd_i;
        end else begin
            req_o <= {1'h0, ~req_o[10:7], 1'h0, ~req_o[5:0]};
        end
    end
endmodule

/* sim/io_bridge_pcie_control_tb.sv */
// Bench for the I/O bridge control block: table rows, then edge cases.
// Assumes a 100 MHz clock; inputs change at falling edges.
`timescale 1ns/100ps

module io_bridge_pcie_control_tb;
    import io_bridge_pkg::*;

    typedef struct packed {
        logic [31:0] ctl;
        logic [6:0]  ins;
        logic [11:0] cmd;
        logic [15:0] exp;
    } row_t;

    logic        clk = 1'h0, rst = 1'h1, iwr = 1'h0, dwr = 1'h0, ldn = 1'h0, ext = 1'h0;
    logic        cv = 1'h0;
    logic [31:0] iwd = '0, dwd = '0;
    logic [6:0]  ins = '0;
    logic [11:0] cmd = '0;
    logic [3:0]  lint = '0;
    logic [7:0]  pv = '0;
    wire  [31:0] ird, drd;
    wire  [15:0] outv, rid;
    wire  [11:0] req;
    wire  [7:0]  lo, go, so, mo;
    wire  [6:0]  hold;
    wire         cal, core, shd, rok, tosb, hid;
    int          num_errors = 0;
    int          total_checks = 0;
    // ins {pm_off, mst_ro, peer, bm, slot, limit, pme}; cmd {dma 5 bits, cfg 7 bits}
    row_t        rows [4] = '{
        '{32'h0040_0100, 7'h7f, 12'hd00, 16'h8de0},
        '{32'h05f6_368e, 7'h7f, 12'hf00, 16'h721f},
        '{32'h0044_1a00, 7'h40, 12'h980, 16'h2482},
        '{32'h0400_0600, 7'h00, 12'hf00, 16'hc080}};

    io_bridge_pcie_control u_dut (
        .sys_clk_i(clk), .sys_rst_i(rst), .index_wr_i(iwr), .index_wdata_i(iwd),
        .index_rdata_o(ird), .data_wr_i(dwr), .data_wdata_i(dwd), .data_rdata_o(drd),
        .gp_training_hold_o(hold), .gp_calibration_reset_o(cal), .gp_core_reset_o(core),
        .link_down_i(ldn), .shadow_reset_o(shd), .dma_req_i(req[11]), .dma_ro_i(req[10]),
        .dma_snoop_i(req[9]), .dma_invalid_i(req[8]), .dma_posted_i(req[7]),
        .pm_arbitration_off_i(ins[6]), .dma_ro_o(outv[15]), .dma_snoop_o(outv[14]),
        .dma_block_o(outv[13]), .dma_drop_o(outv[12]), .dma_unsupported_o(outv[11]),
        .mst_ro_i(ins[5]), .mst_ro_o(outv[10]), .mst_nonsnoop_o(outv[9]),
        .mst_read_order_o(outv[8]), .lock_bypass_allow_o(outv[7]), .p2p_to_sb_i(ins[4]),
        .p2p_allow_o(outv[6]), .bm_event_i(ins[3]), .bm_event_o(outv[5]),
        .external_device_present_i(ext), .retry_handling_o(outv[1]),
        .ext_retry_handling_o(outv[0]), .retry_id_valid_o(rok), .retry_id_o(rid),
        .legacy_int_i(lint), .legacy_int_o(lo), .slot_power_msg_i(ins[2]),
        .slot_power_msg_o(outv[4]), .slot_limit_msg_i(ins[1]), .slot_limit_msg_o(outv[3]),
        .pme_msg_i(ins[0]), .pme_msg_o(outv[2]), .cfg_req_i(req[6]), .cfg_type0_ext_i(req[5]),
        .cfg_device_i(req[4:0]), .cfg_to_sb_o(tosb), .cfg_hidden_o(hid), .gfx_path_i(pv),
        .gfx_path_o(go), .sb_path_i(pv), .sb_path_o(so), .msg_path_i(pv), .msg_path_o(mo));
    io_far_side_model u_far (.sys_clk_i(clk), .cmd_valid_i(cv), .cmd_i(cmd), .req_o(req));

    always #5 clk = ~clk;

    // ----------------
    // Access and compare tasks
    // ----------------
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic en);
        @(negedge clk) {iwr, iwd} = {1'h1, 24'h0, en, a};
        @(negedge clk) {iwr, dwr, dwd} = {1'h0, 1'h1, d};
        @(negedge clk) dwr = 1'h0;
    endtask
    // Data port answers two edges after the index write
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        @(negedge clk) {iwr, iwd} = {1'h1, 25'h0, a};
        @(negedge clk) iwr = 1'h0;
        @(negedge clk) chk(drd, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: the tests need under a thousand cycles
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    // Defaults, table rows, then corner cases
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'h0;
        chk({rok, rid, 1'h0, hold}, 25'h1_0001_7e);
        rd(LINK_CFG_IDX, LINK_CFG_RST);
        rd(DMA_ARB_IDX, DMA_ARB_RST);
        rd(CSR_CNT_IDX, CSR_CNT_RST);
        rd(P2P_CNTL_IDX, P2P_CNTL_RST);
        rd(7'h7f, 32'h0);
        cv = 1'h1;
        foreach (rows[i]) begin
            wr(PCIE_CNTL_IDX, rows[i].ctl, 1'h1);
            {ins, cmd} = {rows[i].ins, rows[i].cmd};
            repeat (2) @(negedge clk);
            chk(outv, rows[i].exp);
            rd(PCIE_CNTL_IDX, rows[i].ctl & PCIE_CNTL_WMASK);
        end
        wr(DMA_ARB_IDX, 32'hdead_beef, 1'h0);
        rd(DMA_ARB_IDX, 32'h0);
        wr(CSR_CNT_IDX, 32'h1234_5678, 1'h1);
        chk(ird, 32'h8a);
        rd(CSR_CNT_IDX, 32'h1234_5678);
        wr(LINK_CFG_IDX, 32'h4050_0000, 1'h1);
        @(negedge clk) chk({core, cal, hold}, 9'h085);
        wr(LINK_CFG_IDX, 32'h8000_0000, 1'h1);
        @(negedge clk) chk({core, cal, hold}, 9'h100);
        wr(PCIE_CNTL_IDX, 32'h1008_0000, 1'h1);
        lint = 4'h5;
        ext = 1'h1;
        repeat (2) @(negedge clk) chk({rok, rid, lo}, 25'h0_0000_50);
        wr(PCIE_CNTL_IDX, PCIE_CNTL_RST, 1'h1);
        @(negedge clk) chk({rok, rid, lo}, 25'h1_0001_05);
        rd(PCIE_CNTL_IDX, PCIE_CNTL_RST | 32'h0001_0000);
        wr(P2P_CNTL_IDX, 32'h0000_1008, 1'h1);
        {cmd, pv} = {12'h063, 8'h3c};
        repeat (2) @(negedge clk) chk({tosb, hid, go, so, mo}, {2'h3, {3{8'h3c}}});
        cmd = 12'h062;
        repeat (2) @(negedge clk) chk({tosb, hid}, 2'h2);
        cmd = 12'h060;
        repeat (2) @(negedge clk) chk({tosb, hid}, 2'h0);
        wr(P2P_CNTL_IDX, P2P_CNTL_RST | 32'h0000_0800, 1'h1);
        @(negedge clk) pv = 8'ha5;
        @(negedge clk) chk({go, so, mo}, {3{8'h3c}});
        @(negedge clk) chk({go, so, mo}, {3{8'ha5}});
        @(negedge clk) ldn = 1'h1;
        @(negedge clk) ldn = 1'h0;
        chk(shd, 1'h1);
        rd(LINK_CFG_IDX, LINK_CFG_RST);
        wrap_up();
    end
endmodule
